// ==== core/vdet_pkg.sv ====
// Purpose: Constants and types for the voltage detect control block
// Assumes: APB register map, 32-bit data, one word per register
// Notes: Offsets are byte addresses
package vdet_pkg;
   localparam logic [11:0] VDET_CTRL_OFF = 12'h000;
   localparam logic [11:0] VDET_STAT_OFF = 12'h004;
   localparam logic [11:0] VDET_MASK_OFF = 12'h008;
   localparam logic [11:0] VDET_ANA_OFF = 12'h00c;
   localparam int VDET_EN_BIT = 15;
   localparam int VDET_SIDL_BIT = 13;
   localparam int VDET_DIR_BIT = 7;
   localparam int VDET_BG_BIT = 6;
   localparam int VDET_IR_BIT = 5;
   localparam logic [15:0] VDET_CTRL_RST = 16'h0000;
   localparam logic [15:0] VDET_CTRL_WMASK = 16'ha08f;
   localparam logic [3:0] VDET_EXT_CODE = 4'hf;
   localparam logic [1:0] VDET_IRQ_RST = 2'h0;
   // Reference start-up time in ns and its cycle count at 4 ns per cycle
   localparam int VDET_TIRVST_NS = 400;
   localparam int VDET_CLK_NS = 4;
   localparam int VDET_TIRVST_CYC = (VDET_TIRVST_NS + VDET_CLK_NS - 1) / VDET_CLK_NS;
   typedef enum logic [1:0] {
      VDET_OFF = 2'b00,
      VDET_WARM = 2'b01,
      VDET_RUN = 2'b10
   } vdet_state_e;
   typedef struct packed {
      logic enable;
      logic stop_in_idle;
      logic crossing_direction;
      logic [3:0] trip_limit_select;
   } vdet_ctrl_s;
endpackage : vdet_pkg

// ==== core/vdet_ctrl.sv ====
// Purpose: Voltage detect control/status register with detection logic
// Assumes: Comparator outputs are synchronous to pclk
// Notes: Analog front end lives outside; this block steers it and watches it
`timescale 1ns/1ps
module vdet_ctrl
   import vdet_pkg::*;
#(
   parameter int TIRVST_CYC = VDET_TIRVST_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic idle_mode,
   input wire logic bandgap_ok,
   input wire logic supply_above,
   output logic analog_on,
   output logic [3:0] trip_level_sel,
   output logic external_trip_input_sel,
   output logic irq
);
   localparam int CW = $clog2(TIRVST_CYC + 1);
   localparam logic [CW-1:0] CNT_DONE = CW'(TIRVST_CYC);

   vdet_ctrl_s ctrl_q, ctrl_d;
   vdet_state_e st_q, st_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic ref_q, ref_d;
   logic bg_q, bg_d;
   logic [1:0] stat_q, stat_d;
   logic [1:0] mask_q, mask_d;
   logic [31:0] prdata_d;
   logic pready_d, pslverr_d, irq_d, on_d, ext_d;
   logic [3:0] lvl_d;
   logic active, acc, wr, rd, hit, crossed, bg_fall;
   logic [15:0] ctrl_rd;

   // A write lands at the edge where the master samples pready high, not one edge early
   assign acc = psel & penable & ~pready;
   assign wr = psel & penable & pready & pwrite;
   assign rd = acc & ~pwrite;
   assign active = ctrl_q.enable & ~(ctrl_q.stop_in_idle & idle_mode);
   assign crossed = ctrl_q.crossing_direction ? supply_above : ~supply_above;
   assign bg_fall = bg_q & ~bandgap_ok;

   always_comb begin
      ctrl_rd = 16'h0000;
      ctrl_rd[VDET_EN_BIT] = ctrl_q.enable;
      ctrl_rd[VDET_SIDL_BIT] = ctrl_q.stop_in_idle;
      ctrl_rd[VDET_DIR_BIT] = ctrl_q.crossing_direction;
      ctrl_rd[VDET_BG_BIT] = bg_q;
      ctrl_rd[VDET_IR_BIT] = ref_q;
      ctrl_rd[3:0] = ctrl_q.trip_limit_select;
   end

   // Register bus: one wait state, answer one cycle after access phase starts
   always_comb begin
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      prdata_d = 32'h0000_0000;
      pready_d = acc;
      pslverr_d = 1'b0;
      hit = 1'b1;
      if (paddr == VDET_CTRL_OFF) begin
         if (wr) begin
            if (pstrb[1]) begin
               ctrl_d.enable = pwdata[VDET_EN_BIT];
               ctrl_d.stop_in_idle = pwdata[VDET_SIDL_BIT];
            end
            if (pstrb[0]) begin
               ctrl_d.crossing_direction = pwdata[VDET_DIR_BIT];
               ctrl_d.trip_limit_select = pwdata[3:0];
            end
         end
         prdata_d = {16'h0000, ctrl_rd};
      end else if (paddr == VDET_STAT_OFF) begin
         prdata_d = {30'h0, stat_q};
      end else if (paddr == VDET_MASK_OFF) begin
         if (wr && pstrb[0]) begin
            mask_d = pwdata[1:0];
         end
         prdata_d = {30'h0, mask_q};
      end else if (paddr == VDET_ANA_OFF) begin
         prdata_d = {29'h0, supply_above, bandgap_ok, active};
      end else begin
         hit = 1'b0;
      end
      pslverr_d = acc & ~hit;
      if (!acc) begin
         prdata_d = 32'h0000_0000;
      end
   end

   // Reference warm-up: counts start-up time after the analog side powers on
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      ref_d = 1'b0;
      case (st_q)
         VDET_OFF: begin
            cnt_d = '0;
            if (active) begin
               st_d = VDET_WARM;
            end
         end
         VDET_WARM: begin
            cnt_d = cnt_q + CW'(1);
            if (!active) begin
               st_d = VDET_OFF;
            end else if (cnt_q >= CNT_DONE - CW'(1)) begin
               st_d = VDET_RUN;
               ref_d = 1'b1;
            end
         end
         VDET_RUN: begin
            ref_d = active;
            if (!active) begin
               st_d = VDET_OFF;
            end
         end
         default: begin
            st_d = VDET_OFF;
         end
      endcase
   end

   // Status: bit0 detection flag, bit1 band gap lost; read clears, set wins
   always_comb begin
      stat_d = stat_q;
      bg_d = bandgap_ok;
      if (rd && paddr == VDET_STAT_OFF) begin
         stat_d = 2'b00;
      end
      if (active && ref_q && crossed) begin
         stat_d[0] = 1'b1;
      end
      if (bg_fall) begin
         stat_d[1] = 1'b1;
      end
      irq_d = |(stat_d & mask_d);
      on_d = ctrl_d.enable & ~(ctrl_d.stop_in_idle & idle_mode);
      ext_d = ctrl_d.trip_limit_select == VDET_EXT_CODE;
      lvl_d = ctrl_d.trip_limit_select;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= VDET_CTRL_RST[6:0];
         mask_q <= VDET_IRQ_RST;
         stat_q <= VDET_IRQ_RST;
         st_q <= VDET_OFF;
         cnt_q <= '0;
         ref_q <= 1'b0;
         bg_q <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
         analog_on <= 1'b0;
         trip_level_sel <= 4'h0;
         external_trip_input_sel <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         ref_q <= ref_d;
         bg_q <= bg_d;
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
         irq <= irq_d;
         analog_on <= on_d;
         trip_level_sel <= lvl_d;
         external_trip_input_sel <= ext_d;
      end
   end

   sequence warm_start;
      st_q == VDET_OFF && active;
   endsequence
   sequence warm_hold;
      active [*2];
   endsequence

   enable_drives_on_a: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> analog_on == $past(on_d))
      else $error("analog enable does not follow control");
   idle_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_q.stop_in_idle && idle_mode) |-> !active)
      else $error("detector runs in idle with stop set");
   rise_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      (active && ref_q && ctrl_q.crossing_direction && supply_above) |=> stat_q[0])
      else $error("rising crossing not flagged");
   fall_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      (active && ref_q && !ctrl_q.crossing_direction && !supply_above) |=> stat_q[0])
      else $error("falling crossing not flagged");
   // Checked one edge on, so the reset value of the copy is never compared
   bandgap_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> (ctrl_rd[VDET_BG_BIT] == bg_q && bg_q == $past(bandgap_ok)))
      else $error("band gap bit mismatch");
   ref_warm_a: assert property (@(posedge pclk) disable iff (!presetn)
      warm_start ##1 warm_hold |-> !ref_q)
      else $error("reference stable too early");
   no_flag_unstable_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!ref_q && !bg_fall && !stat_q[0]) |=> !stat_q[0])
      else $error("flag set while reference unstable");
   ext_route_a: assert property (@(posedge pclk) disable iff (!presetn)
      external_trip_input_sel |-> trip_level_sel == VDET_EXT_CODE)
      else $error("external input routed with wrong code");
   level_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> trip_level_sel == $past(lvl_d))
      else $error("trip level not passed through");
   irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
      (stat_q[0] && mask_q[0]) |-> irq)
      else $error("unmasked flag without interrupt");
   reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_rd & ~VDET_CTRL_WMASK & 16'hdf9f) == 16'h0000)
      else $error("reserved bit reads nonzero");

   // Register bus handshake: one wait state, a single-cycle answer
   sequence bus_access;
      psel && penable && !pready;
   endsequence
   sequence bus_answer;
      pready ##1 !pready;
   endsequence

   ready_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
      bus_access |=> bus_answer)
      else $error("bus access not answered in one cycle");
   slverr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error response without ready");

   // Power and reference follow the enable and the idle stop
   enable_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_q.enable |-> !active)
      else $error("detector active while disabled");
   idle_run_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_q.enable && !ctrl_q.stop_in_idle) |-> active)
      else $error("detector stopped without idle stop");
   ref_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      !active |=> !ref_q)
      else $error("reference stable kept while inactive");

   // Routing and interrupt level
   ext_code_a: assert property (@(posedge pclk) disable iff (!presetn)
      (trip_level_sel == VDET_EXT_CODE) |-> external_trip_input_sel)
      else $error("external code without external routing");
   irq_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
      ((stat_q & mask_q) == 2'b00) |-> !irq)
      else $error("interrupt without unmasked flag");
   // Read clear loses only to a new event in the same cycle
   stat_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rd && paddr == VDET_STAT_OFF && !(active && ref_q && crossed) && !bg_fall)
      |=> stat_q == 2'b00)
      else $error("status not cleared by read");
   stat_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      (active && ref_q && crossed && rd && paddr == VDET_STAT_OFF) |=> stat_q[0])
      else $error("event lost to read clear");
endmodule : vdet_ctrl

// ==== sim/vdet_ctrl_tb_top.sv ====
// Purpose: Self-checking bench for the voltage detect control block
// Assumes: One wait state APB slave, reference start-up shortened to 4 cycles
// Notes: Status reads clear the flags, so each check reads status twice where needed
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module vdet_ctrl_tb_top;
   import vdet_pkg::*;
   localparam int TCYC = 4;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic idle_mode, bandgap_ok, supply_above, analog_on, external_trip_input_sel, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_q;
   logic [3:0] pstrb, trip_level_sel;
   logic [15:0] w;
   int n_errors = 0;
   int cmp_count = 0;
   vdet_ctrl #(.TIRVST_CYC(TCYC)) u_vdet_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
      .bandgap_ok(bandgap_ok), .supply_above(supply_above), .analog_on(analog_on),
      .trip_level_sel(trip_level_sel), .external_trip_input_sel(external_trip_input_sel),
      .irq(irq));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   function automatic logic [31:0] ctrl_exp(input logic [15:0] v, input logic bg, input logic rs);
      return {16'h0000, v & VDET_CTRL_WMASK} | {25'h0, bg, rs, 5'h00};
   endfunction : ctrl_exp
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   // Request held until pready is seen; an idle edge follows so no signal is set twice
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) n_errors++;
      rd_q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd_q, e)
   endtask : rd
   task automatic end_of_test();
      $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #20000;
      n_errors++;
      end_of_test();
   end
   initial begin
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
      pstrb = 4'hf; idle_mode = 1'b0; bandgap_ok = 1'b1; supply_above = 1'b0;
      presetn = 1'b0; err = 1'b0; rd_q = 32'h0; w = 16'h0000;
      void'($urandom(66));
      cyc(16);
      presetn <= 1'b1;
      cyc(1);
      `CHK(analog_on, 1'b0)
      rd(VDET_CTRL_OFF, ctrl_exp(16'h0000, 1'b1, 1'b0));
      // Random words with every reserved bit exercised, limit corners first
      for (int i = 0; i < 8; i++) begin
         w = 16'($urandom()) & 16'h7fff;
         if (i < 3) w[3:0] = (i == 0) ? VDET_EXT_CODE : 4'(14 * (i - 1));
         apb(1'b1, VDET_CTRL_OFF, {16'hffff, w});
         rd(VDET_CTRL_OFF, ctrl_exp(w, 1'b1, 1'b0));
         `CHK(trip_level_sel, w[3:0])
         `CHK(external_trip_input_sel, w[3:0] == VDET_EXT_CODE)
         `CHK(analog_on, 1'b0)
      end
      supply_above <= 1'b1;
      apb(1'b1, VDET_CTRL_OFF, 32'h0000_8080);
      rd(VDET_STAT_OFF, 32'h0);
      cyc(TCYC + 4);
      `CHK(analog_on, 1'b1)
      rd(VDET_CTRL_OFF, ctrl_exp(16'h8080, 1'b1, 1'b1));
      rd(VDET_STAT_OFF, 32'h1);
      `CHK(irq, 1'b0)
      rd(VDET_ANA_OFF, 32'h7);
      supply_above <= 1'b0;
      cyc(2);
      apb(1'b0, VDET_STAT_OFF, 32'h0);
      rd(VDET_STAT_OFF, 32'h0);
      apb(1'b1, VDET_CTRL_OFF, 32'h0000_8000);
      cyc(2);
      rd(VDET_STAT_OFF, 32'h1);
      apb(1'b1, VDET_MASK_OFF, 32'h1);
      cyc(2);
      `CHK(irq, 1'b1)
      supply_above <= 1'b1;
      cyc(2);
      apb(1'b0, VDET_STAT_OFF, 32'h0);
      cyc(3);
      `CHK(irq, 1'b0)
      bandgap_ok <= 1'b0;
      cyc(2);
      apb(1'b0, VDET_CTRL_OFF, 32'h0);
      `CHK(rd_q[6], 1'b0)
      rd(VDET_STAT_OFF, 32'h2);
      bandgap_ok <= 1'b1;
      apb(1'b1, VDET_CTRL_OFF, 32'h0000_a000);
      idle_mode <= 1'b1;
      cyc(3);
      `CHK(analog_on, 1'b0)
      rd(VDET_CTRL_OFF, ctrl_exp(16'ha000, 1'b1, 1'b0));
      apb(1'b1, VDET_CTRL_OFF, 32'h0000_8000);
      cyc(2);
      `CHK(analog_on, 1'b1)
      idle_mode <= 1'b0;
      apb(1'b0, 12'h010, 32'h0);
      `CHK(err, 1'b1)
      // Reset in mid-run with the detector on
      presetn <= 1'b0;
      cyc(2);
      `CHK(analog_on, 1'b0)
      `CHK(trip_level_sel, 4'h0)
      presetn <= 1'b1;
      cyc(1);
      rd(VDET_CTRL_OFF, ctrl_exp(16'h0000, 1'b1, 1'b0));
      end_of_test();
   end
endmodule : vdet_ctrl_tb_top
